// ---- inc/mtr_pkg.sv ----
package mtr_pkg;

   // ************************************************************
   // Memory type encodings
   // ************************************************************
   localparam logic [2:0] MT_UNCACHEABLE       = 3'h0;
   localparam logic [2:0] MT_WRITE_COMBINING   = 3'h1;
   localparam logic [2:0] MT_WRITE_THROUGH     = 3'h4;
   localparam logic [2:0] MT_WRITE_PROTECT     = 3'h5;
   localparam logic [2:0] MT_WRITE_BACK        = 3'h6;
   localparam logic [2:0] MT_UNCACHEABLE_MINUS = 3'h7;

   // ************************************************************
   // Register offsets (byte addresses)
   // ************************************************************
   localparam int          ADDR_W          = 12;
   localparam logic [11:0] PAT_LO_OFS      = 12'h000;
   localparam logic [11:0] PAT_HI_OFS      = 12'h004;
   localparam logic [11:0] RANGE_CTRL_OFS  = 12'h008;
   localparam logic [11:0] SYS_CFG_OFS     = 12'h00c;
   localparam logic [11:0] STATUS_OFS      = 12'h010;
   localparam logic [11:0] FIXED_BASE_OFS  = 12'h020;
   localparam int          FIXED_WIN_BYTES = 32;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int TYPE_MSB          = 2;
   localparam int WR_ROUTE_BIT      = 3;
   localparam int RD_ROUTE_BIT      = 4;
   localparam int RANGE_EN_BIT      = 0;
   localparam int ROUTE_EN_BIT      = 18;
   localparam int ROUTE_MOD_EN_BIT  = 19;
   localparam int ST_TYPE_LSB       = 0;
   localparam int ST_DRAM_BIT       = 4;
   localparam int ST_RSVD_BIT       = 5;

   // ************************************************************
   // Values after reset
   // ************************************************************
   localparam logic [63:0] PAT_RESET   = 64'h0007040600070406;
   localparam logic [4:0]  FIXED_RESET = 5'h00;

endpackage : mtr_pkg

// ---- logic/mtr_resolver.sv ----
`timescale 1ns/100ps

module mtr_resolver
   import mtr_pkg::*;
#(
   parameter int NUM_FIXED = 8,
   parameter int FIX_IDX_W = 3
) (
   input  wire logic                 clk,          // Core clock
   input  wire logic                 rst,          // Sync reset, high
   input  wire logic                 psel,         // APB select
   input  wire logic                 penable,      // APB enable
   input  wire logic                 pwrite,       // APB direction
   input  wire logic [ADDR_W-1:0]    paddr,        // APB byte address
   input  wire logic [31:0]          pwdata,       // APB write data
   input  wire logic [3:0]           pstrb,        // APB byte strobes
   output logic                      pready,       // APB ready
   output logic [31:0]               prdata,       // APB read data
   output logic                      pslverr,      // APB error
   input  wire logic                 lk_valid,     // Lookup request
   input  wire logic [2:0]           lk_pat_idx,   // Page index bits
   input  wire logic [2:0]           lk_var_type,  // Variable range type
   input  wire logic                 lk_fixed_hit, // Address in fixed range
   input  wire logic [FIX_IDX_W-1:0] lk_fixed_idx, // Fixed range number
   input  wire logic                 lk_is_write,  // Access is a write
   output logic                      res_valid,    // Result valid
   output logic [2:0]                eff_type,     // Effective type
   output logic                      route_dram,   // 1 memory, 0 I/O
   output logic                      combo_rsvd    // Reserved pairing
);

   // ************************************************************
   // Helper functions
   // ************************************************************

   // Supported type encoding check
   function automatic logic type_ok(input logic [7:0] t);
      type_ok = (t == {5'h00, MT_UNCACHEABLE}) ||
                (t == {5'h00, MT_WRITE_COMBINING}) ||
                (t == {5'h00, MT_WRITE_THROUGH}) ||
                (t == {5'h00, MT_WRITE_PROTECT}) ||
                (t == {5'h00, MT_WRITE_BACK}) ||
                (t == {5'h00, MT_UNCACHEABLE_MINUS});
   endfunction : type_ok

   // Valid range type (no minus encoding there)
   function automatic logic range_ok(input logic [2:0] t);
      range_ok = type_ok({5'h00, t}) && (t != MT_UNCACHEABLE_MINUS);
   endfunction : range_ok

   // Page type merged with range type
   function automatic logic [2:0] merge(input logic [2:0] pa,
                                        input logic [2:0] rt);
      merge = MT_UNCACHEABLE;
      case (pa)
         MT_UNCACHEABLE: merge = MT_UNCACHEABLE;
         MT_UNCACHEABLE_MINUS: begin
            if (rt == MT_WRITE_COMBINING) begin
               merge = MT_WRITE_COMBINING;
            end
         end
         MT_WRITE_COMBINING: merge = MT_WRITE_COMBINING;
         MT_WRITE_PROTECT: begin
            if (rt == MT_WRITE_PROTECT || rt == MT_WRITE_BACK) begin
               merge = MT_WRITE_PROTECT;
            end
         end
         MT_WRITE_THROUGH: begin
            if (rt == MT_WRITE_THROUGH || rt == MT_WRITE_BACK) begin
               merge = MT_WRITE_THROUGH;
            end
         end
         MT_WRITE_BACK: merge = rt;
         default: merge = MT_UNCACHEABLE;
      endcase
   endfunction : merge

   // Routing bits against type validity
   function automatic logic route_rsvd(input logic       rd,
                                       input logic       wr,
                                       input logic [2:0] t);
      case ({rd, wr})
         2'b00: route_rsvd = (t == MT_WRITE_BACK);
         2'b01: route_rsvd = (t != MT_UNCACHEABLE) &&
                             (t != MT_WRITE_COMBINING);
         2'b10: route_rsvd = (t != MT_UNCACHEABLE) &&
                             (t != MT_WRITE_PROTECT);
         2'b11: route_rsvd = (t == MT_WRITE_PROTECT);
         default: route_rsvd = 1'b1;
      endcase
   endfunction : route_rsvd

   // Fixed field as software sees it
   function automatic logic [7:0] fix_view(input logic [4:0] f,
                                           input logic       mod_en);
      fix_view = mod_en ? {3'h0, f} : {5'h00, f[TYPE_MSB:0]};
   endfunction : fix_view

   // ************************************************************
   // Settings storage
   // ************************************************************
   logic [63:0]          pat_ff;
   logic                 range_en_ff;
   logic                 route_en_ff;
   logic                 mod_en_ff;
   logic [4:0]           fixed_ff [NUM_FIXED];
   logic                 pready_ff;
   logic [31:0]          prdata_ff;
   logic                 pslverr_ff;
   logic                 res_valid_ff;
   logic [2:0]           eff_type_ff;
   logic                 route_dram_ff;
   logic                 combo_rsvd_ff;

   logic                 acc_take;
   logic                 acc_commit;
   logic [31:0]          nxt_prdata;
   logic                 nxt_pslverr;
   logic [ADDR_W-1:0]    fix_ofs;
   logic                 in_fix_win;
   logic                 pat_wr_ok;
   logic [2:0]           pa_sel;
   logic [4:0]           fix_sel;
   logic [2:0]           rt_sel;
   logic                 dir_bit;
   logic [2:0]           nxt_eff_type;
   logic                 nxt_route_dram;
   logic                 nxt_combo_rsvd;

   // ************************************************************
   // APB access decode
   // ************************************************************

   // First access cycle raises ready, second cycle commits
   assign acc_take   = psel && penable && !pready_ff;
   assign acc_commit = psel && penable && pready_ff;
   assign fix_ofs    = paddr - FIXED_BASE_OFS;
   assign in_fix_win = (paddr >= FIXED_BASE_OFS) &&
                       (fix_ofs < ADDR_W'(FIXED_WIN_BYTES));

   // All four page fields in a written word must be supported
   always_comb begin
      pat_wr_ok = 1'b1;
      for (int j = 0; j < 4; j++) begin
         if (!type_ok(pwdata[8*j +: 8])) begin
            pat_wr_ok = 1'b0;
         end
      end
   end

   // Read data and error for the addressed register
   always_comb begin
      nxt_prdata  = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      case (paddr)
         PAT_LO_OFS: begin
            nxt_prdata  = pat_ff[31:0];
            nxt_pslverr = pwrite && !pat_wr_ok;
         end
         PAT_HI_OFS: begin
            nxt_prdata  = pat_ff[63:32];
            nxt_pslverr = pwrite && !pat_wr_ok;
         end
         RANGE_CTRL_OFS: nxt_prdata[RANGE_EN_BIT] = range_en_ff;
         SYS_CFG_OFS: begin
            nxt_prdata[ROUTE_EN_BIT]     = route_en_ff;
            nxt_prdata[ROUTE_MOD_EN_BIT] = mod_en_ff;
         end
         STATUS_OFS: begin
            nxt_prdata[ST_TYPE_LSB +: 3] = eff_type_ff;
            nxt_prdata[ST_DRAM_BIT]      = route_dram_ff;
            nxt_prdata[ST_RSVD_BIT]      = combo_rsvd_ff;
         end
         default: begin
            if (in_fix_win && paddr[1:0] == 2'b00) begin
               for (int j = 0; j < 4; j++) begin
                  if (int'(fix_ofs) + j < NUM_FIXED) begin
                     nxt_prdata[8*j +: 8] = fix_view(
                        fixed_ff[int'(fix_ofs) + j], mod_en_ff);
                  end
               end
            end else begin
               nxt_pslverr = 1'b1;
            end
         end
      endcase
   end

   // Ready handshake and registered answer
   always_ff @(posedge clk) begin
      if (rst) begin
         pready_ff  <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (acc_take) begin
         pready_ff  <= 1'b1;
         prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
         pslverr_ff <= nxt_pslverr;
      end else begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end
   end

   // ************************************************************
   // Register writes
   // ************************************************************

   // Page attribute fields, refused whole on a bad encoding
   always_ff @(posedge clk) begin
      if (rst) begin
         pat_ff <= PAT_RESET;
      end else if (acc_commit && pwrite && !pslverr_ff) begin
         for (int j = 0; j < 4; j++) begin
            if (paddr == PAT_LO_OFS && pstrb[j]) begin
               pat_ff[8*j +: 8] <= pwdata[8*j +: 8];
            end
            if (paddr == PAT_HI_OFS && pstrb[j]) begin
               pat_ff[32 + 8*j +: 8] <= pwdata[8*j +: 8];
            end
         end
      end
   end

   // Range enable and system configuration enables
   always_ff @(posedge clk) begin
      if (rst) begin
         range_en_ff <= 1'b0;
         route_en_ff <= 1'b0;
         mod_en_ff   <= 1'b0;
      end else if (acc_commit && pwrite) begin
         if (paddr == RANGE_CTRL_OFS && pstrb[0]) begin
            range_en_ff <= pwdata[RANGE_EN_BIT];
         end
         if (paddr == SYS_CFG_OFS && pstrb[2]) begin
            route_en_ff <= pwdata[ROUTE_EN_BIT];
            mod_en_ff   <= pwdata[ROUTE_MOD_EN_BIT];
         end
      end
   end

   // Fixed range fields; routing bits locked unless modify enabled
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_FIXED; i++) begin
            fixed_ff[i] <= FIXED_RESET;
         end
      end else if (acc_commit && pwrite && !pslverr_ff && in_fix_win) begin
         for (int j = 0; j < 4; j++) begin
            if (pstrb[j] && int'(fix_ofs) + j < NUM_FIXED) begin
               fixed_ff[int'(fix_ofs) + j][TYPE_MSB:0] <=
                  pwdata[8*j +: 3];
               if (mod_en_ff) begin
                  fixed_ff[int'(fix_ofs) + j][RD_ROUTE_BIT:WR_ROUTE_BIT]
                     <= pwdata[8*j + WR_ROUTE_BIT +: 2];
               end
            end
         end
      end
   end

   // ************************************************************
   // Type merging and routing
   // ************************************************************

   // Settings are only local; nothing is checked against other cores
   assign pa_sel  = pat_ff[{lk_pat_idx, 3'b000} +: 3];
   assign fix_sel = fixed_ff[lk_fixed_idx];
   assign rt_sel  = !range_en_ff ? MT_UNCACHEABLE :
                    lk_fixed_hit ? fix_sel[TYPE_MSB:0] : lk_var_type;
   assign dir_bit = lk_is_write ? fix_sel[WR_ROUTE_BIT]
                                : fix_sel[RD_ROUTE_BIT];

   // Merge from current settings for this lookup
   always_comb begin
      nxt_eff_type   = merge(pa_sel, rt_sel);
      nxt_route_dram = lk_fixed_hit && route_en_ff && dir_bit;
      nxt_combo_rsvd = !range_ok(rt_sel) ||
                       (lk_fixed_hit && route_en_ff &&
                        route_rsvd(fix_sel[RD_ROUTE_BIT],
                                   fix_sel[WR_ROUTE_BIT],
                                   fix_sel[TYPE_MSB:0]));
      if (!route_en_ff) begin
         nxt_route_dram = 1'b0;
      end
   end

   // Result registers
   always_ff @(posedge clk) begin
      if (rst) begin
         res_valid_ff  <= 1'b0;
         eff_type_ff   <= MT_UNCACHEABLE;
         route_dram_ff <= 1'b0;
         combo_rsvd_ff <= 1'b0;
      end else begin
         res_valid_ff <= lk_valid;
         if (lk_valid) begin
            eff_type_ff   <= nxt_eff_type;
            route_dram_ff <= nxt_route_dram;
            combo_rsvd_ff <= nxt_combo_rsvd;
         end
      end
   end

   assign pready     = pready_ff;
   assign prdata     = prdata_ff;
   assign pslverr    = pslverr_ff;
   assign res_valid  = res_valid_ff;
   assign eff_type   = eff_type_ff;
   assign route_dram = route_dram_ff;
   assign combo_rsvd = combo_rsvd_ff;

   // ************************************************************
   // Assertions
   // ************************************************************
   logic [2*NUM_FIXED-1:0] route_bits;

   // All routing bits gathered for stability checks
   always_comb begin
      for (int i = 0; i < NUM_FIXED; i++) begin
         route_bits[2*i +: 2] = fixed_ff[i][RD_ROUTE_BIT:WR_ROUTE_BIT];
      end
   end

   pat_uc_a: assert property (@(posedge clk) disable iff (rst)
      lk_valid && pa_sel == MT_UNCACHEABLE |=> eff_type_ff == MT_UNCACHEABLE)
      else $error("uncacheable page not uncacheable");
   ucm_wc_a: assert property (@(posedge clk) disable iff (rst)
      lk_valid && pa_sel == MT_UNCACHEABLE_MINUS |=>
      eff_type_ff == ($past(rt_sel) == MT_WRITE_COMBINING ?
                      MT_WRITE_COMBINING : MT_UNCACHEABLE))
      else $error("uncacheable minus merge wrong");
   pat_wc_a: assert property (@(posedge clk) disable iff (rst)
      lk_valid && pa_sel == MT_WRITE_COMBINING |=>
      eff_type_ff == MT_WRITE_COMBINING)
      else $error("combining page not combining");
   pat_wp_a: assert property (@(posedge clk) disable iff (rst)
      lk_valid && pa_sel == MT_WRITE_PROTECT && rt_sel == MT_WRITE_BACK
      |=> eff_type_ff == MT_WRITE_PROTECT)
      else $error("protect page over write-back wrong");
   pat_wb_a: assert property (@(posedge clk) disable iff (rst)
      lk_valid && pa_sel == MT_WRITE_BACK |=> eff_type_ff == $past(rt_sel))
      else $error("write-back page not range type");
   range_off_a: assert property (@(posedge clk) disable iff (rst)
      lk_valid && !range_en_ff && pa_sel == MT_WRITE_BACK |=>
      eff_type_ff == MT_UNCACHEABLE)
      else $error("disabled ranges not uncacheable");
   route_off_a: assert property (@(posedge clk) disable iff (rst)
      lk_valid && !route_en_ff |=> res_valid_ff && !route_dram_ff)
      else $error("disabled routing reached memory");
   wr_route_a: assert property (@(posedge clk) disable iff (rst)
      lk_valid && lk_fixed_hit && route_en_ff && lk_is_write |=>
      route_dram_ff == $past(fix_sel[WR_ROUTE_BIT]))
      else $error("write routing wrong");
   rd_route_a: assert property (@(posedge clk) disable iff (rst)
      lk_valid && lk_fixed_hit && route_en_ff && !lk_is_write |=>
      route_dram_ff == $past(fix_sel[RD_ROUTE_BIT]))
      else $error("read routing wrong");
   mod_lock_a: assert property (@(posedge clk) disable iff (rst)
      !mod_en_ff |=> $stable(route_bits))
      else $error("routing bits changed while locked");
   apb_ready_a: assert property (@(posedge clk) disable iff (rst)
      acc_take |=> pready_ff ##1 !pready_ff)
      else $error("ready not a single cycle");

endmodule : mtr_resolver

// ---- verif/mtr_access_model.sv ----
`timescale 1ns/100ps

// ************************************************************
// Memory access path issuing lookups
// ************************************************************
module mtr_access_model
   import mtr_pkg::*;
(
   input  wire logic       clk,          // Core clock
   input  wire logic       rst,          // Sync reset, high
   input  wire logic       go,           // Issue one lookup
   output logic            lk_valid,     // Lookup request
   input  wire logic       res_valid,    // Result valid
   input  wire logic [2:0] eff_type,     // Effective type
   input  wire logic       route_dram,   // 1 memory, 0 I/O
   output logic            done_ff,      // Answer captured
   output logic [2:0]      got_type_ff,  // Captured type
   output logic            got_route_ff, // Captured route
   output logic            late_ff       // Answer off its slot
);
   logic asked_ff;

   // One lookup for every cycle of go
   assign lk_valid = go;

   // Capture each answer and watch its slot
   always_ff @(posedge clk) begin
      if (rst) begin
         asked_ff     <= 1'h0;
         done_ff      <= 1'h0;
         got_type_ff  <= 3'h0;
         got_route_ff <= 1'h0;
         late_ff      <= 1'h0;
      end else begin
         asked_ff <= lk_valid;
         done_ff  <= res_valid;
         if (res_valid) begin
            got_type_ff  <= eff_type;
            got_route_ff <= route_dram;
         end
         if (res_valid != asked_ff) begin
            late_ff <= 1'h1;
         end
      end
   end
endmodule : mtr_access_model

// ---- verif/mtr_resolver_test.sv ----
`timescale 1ns/100ps

module mtr_resolver_test
   import mtr_pkg::*;
;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr;
   logic        go, lk_valid, lk_fixed_hit, lk_is_write, res_valid;
   logic        route_dram, done, got_route, late, err, rsvd, ex;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [31:0] fw = 32'h04150918;
   logic [31:0] fr = 32'h1d110c06;
   logic [7:0]  fb;
   logic [2:0]  lk_pat_idx, lk_var_type, lk_fixed_idx, eff_type;
   logic [2:0]  got_type, rt;
   logic [63:0] page_attribute_table;
   logic [2:0]  ptyp [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
   int          mismatches, checked;

   // ************************************************************
   // Clock, design and access path
   // ************************************************************
   always #2.5 clk = ~clk;

   mtr_resolver i_mtr_resolver (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .lk_valid(lk_valid), .lk_pat_idx(lk_pat_idx),
      .lk_var_type(lk_var_type), .lk_fixed_hit(lk_fixed_hit),
      .lk_fixed_idx(lk_fixed_idx), .lk_is_write(lk_is_write),
      .res_valid(res_valid), .eff_type(eff_type),
      .route_dram(route_dram), .combo_rsvd(rsvd));

   mtr_access_model i_mtr_access_model (.clk(clk), .rst(rst), .go(go),
      .lk_valid(lk_valid), .res_valid(res_valid), .eff_type(eff_type),
      .route_dram(route_dram), .done_ff(done), .got_type_ff(got_type),
      .got_route_ff(got_route), .late_ff(late));

   // ************************************************************
   // Expectation, compare, bus and lookup tasks
   // ************************************************************
   function automatic logic [2:0] merge(input logic [2:0] p, r);
      case (p)
         MT_UNCACHEABLE:       return MT_UNCACHEABLE;
         MT_WRITE_COMBINING:   return MT_WRITE_COMBINING;
         MT_UNCACHEABLE_MINUS: return (r == MT_WRITE_COMBINING) ? r : 3'h0;
         MT_WRITE_PROTECT:     return (r == MT_WRITE_PROTECT ||
                                       r == MT_WRITE_BACK) ? p : 3'h0;
         MT_WRITE_THROUGH:     return (r == MT_WRITE_THROUGH ||
                                       r == MT_WRITE_BACK) ? p : 3'h0;
         default:              return r;
      endcase
   endfunction : merge

   // Reserved routing and type pairing of one fixed field
   function automatic logic bad(input logic [4:0] f);
      case (f[4:3])
         2'b00:   return f[2:0] == MT_WRITE_BACK;
         2'b01:   return !(f[2:0] == MT_UNCACHEABLE ||
                           f[2:0] == MT_WRITE_COMBINING);
         2'b10:   return !(f[2:0] == MT_UNCACHEABLE ||
                           f[2:0] == MT_WRITE_PROTECT);
         default: return f[2:0] == MT_WRITE_PROTECT;
      endcase
   endfunction : bad

   task automatic report_and_stop();
      if (mismatches == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel    <= 1'h1;
      penable <= 1'h0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      if (pready !== 1'h1) begin
         mismatches++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic look(input logic [2:0] pi, r, input logic fh,
                       input logic [2:0] fi, input logic w,
                       input logic [2:0] et, input logic er);
      int n;
      @(posedge clk);
      lk_pat_idx   <= pi;
      lk_var_type  <= r;
      lk_fixed_hit <= fh;
      lk_fixed_idx <= fi;
      lk_is_write  <= w;
      go           <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (done !== 1'h1 && n < 8);
      if (done !== 1'h1) begin
         mismatches++;
         report_and_stop();
      end
      chk({29'h0, got_type}, {29'h0, et});
      chk({31'h0, got_route}, {31'h0, er});
      chk({31'h0, late}, 32'h0);
   endtask : look

   task automatic wpat(input logic [63:0] v);
      apb(1'h1, PAT_LO_OFS, v[31:0]);
      chk({31'h0, err}, 32'h0);
      apb(1'h1, PAT_HI_OFS, v[63:32]);
      chk({31'h0, err}, 32'h0);
   endtask : wpat

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      {clk, psel, penable, pwrite, go, lk_fixed_hit, lk_is_write} = '0;
      {paddr, pwdata, lk_pat_idx, lk_var_type, lk_fixed_idx} = '0;
      rst = 1'h1;
      mismatches = 0;
      checked = 0;
      void'($urandom(32'h871c));
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      apb(1'h0, PAT_LO_OFS, 32'h0);
      chk(rd, PAT_RESET[31:0]);
      apb(1'h0, PAT_HI_OFS, 32'h0);
      chk(rd, PAT_RESET[63:32]);
      apb(1'h0, SYS_CFG_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, FIXED_BASE_OFS, 32'h0);
      chk(rd, {4{3'h0, FIXED_RESET}});
      apb(1'h0, 12'h100, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Range registers still off after reset
      for (int i = 0; i < 8; i++)
         look(i[2:0], 3'h6, 1'h0, 3'h0, 1'h0,
              merge(PAT_RESET[i*8+:3], 3'h0), 1'h0);
      apb(1'h1, RANGE_CTRL_OFS, 32'h1);
      // Random page tables against random range types
      for (int k = 0; k < 24; k++) begin
         for (int f = 0; f < 8; f++)
            page_attribute_table[f*8+:8] = {5'h0, ptyp[$urandom % 6]};
         wpat(page_attribute_table);
         for (int i = 0; i < 8; i++) begin
            rt = ptyp[$urandom % 5];
            look(i[2:0], rt, 1'h0, 3'h0, 1'($urandom % 2),
                 merge(page_attribute_table[i*8+:3], rt), 1'h0);
         end
      end
      // Unsupported page byte leaves the word alone
      apb(1'h1, PAT_LO_OFS, 32'h00020606);
      chk({31'h0, err}, 32'h1);
      apb(1'h0, PAT_LO_OFS, 32'h0);
      chk(rd, page_attribute_table[31:0]);
      // Fixed routing: modify enable off, then on, then enable
      wpat({8{8'h06}});
      apb(1'h1, FIXED_BASE_OFS, fw);
      apb(1'h0, FIXED_BASE_OFS, 32'h0);
      chk(rd, 32'h04050100);
      apb(1'h1, SYS_CFG_OFS, 32'h00080000);
      apb(1'h1, FIXED_BASE_OFS, fw);
      apb(1'h1, FIXED_BASE_OFS + 12'h004, fr);
      apb(1'h0, FIXED_BASE_OFS + 12'h004, 32'h0);
      chk(rd, fr);
      apb(1'h0, FIXED_BASE_OFS, 32'h0);
      chk(rd, fw);
      look(3'h0, 3'h6, 1'h1, 3'h0, 1'h1, 3'h0, 1'h0);
      apb(1'h1, SYS_CFG_OFS, 32'h000c0000);
      // Fields 0..3 valid pairings, fields 4..7 reserved ones
      for (int k = 0; k < 16; k++) begin
         fb = (k < 8) ? fw[(k/2)*8+:8] : fr[(k/2-4)*8+:8];
         ex = bad(fb[4:0]);
         look(3'h0, 3'h6, 1'h1, 3'(k/2), k[0], fb[2:0],
              fb[k[0] ? 3 : 4]);
         chk({31'h0, rsvd}, {31'h0, ex});
      end
      look(3'h0, 3'h6, 1'h0, 3'h0, 1'h1, 3'h6, 1'h0);
      // Modify enable off again: bits hidden and kept
      apb(1'h1, SYS_CFG_OFS, 32'h00040000);
      apb(1'h1, FIXED_BASE_OFS, 32'h04050100);
      apb(1'h0, FIXED_BASE_OFS, 32'h0);
      chk(rd, 32'h04050100);
      look(3'h0, 3'h6, 1'h1, 3'h0, 1'h1, 3'h0, 1'h1);
      // Status shows last lookup: memory route, uncacheable, no reserve
      apb(1'h0, STATUS_OFS, 32'h0);
      chk(rd, 32'h00000010);
      report_and_stop();
   end
endmodule : mtr_resolver_test
